/* File: hw/pdx_ctrl.sv */
// Controller end: sequences clock-enable, chip select and clock around power-down
`timescale 1ns/1ns
`default_nettype none
module pdx_ctrl
	import pdx_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	pdx_if.ctrl             link,
	input  wire logic       pd_req_i,
	input  wire logic       cmd_req_i,
	input  wire logic [5:0] cmd_ca_i,
	input  wire logic       cmd_is_mrw_i,
	input  wire logic       cmd_is_zq_i,
	input  wire logic       blocking_op_i,
	input  wire logic       osc_run_i,
	input  wire logic       refresh_due_i,
	output var  logic       cmd_ack_o,
	output var  logic       in_pd_o,
	output var  logic       clk_stop_ok_o
);
	typedef struct packed {
		pdx_cst_t         st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] cmdgap;
		logic [CNT_W-1:0] hold;
		logic             cke;
		logic             cs;
		logic             ck;
		logic [5:0]       ca;
		logic             ack;
		logic             stop_ok;
		logic             pd;
	} pdx_cst_s_t;

	pdx_cst_s_t s_reg;
	pdx_cst_s_t s_next;

	// Larger of two counts; a wait bound by two minima must cover both
	function automatic logic [CNT_W-1:0] pdx_max(input logic [CNT_W-1:0] a,
			input logic [CNT_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	// Sequencer; each wait uses the max of time and cycle minima
	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.ca = 6'h00;
		s_next.stop_ok = 1'b0;
		if (s_reg.cnt != '0) begin
			s_next.cnt = s_reg.cnt - CNT_W'(1);
		end
		if (s_reg.cmdgap != '0) begin
			s_next.cmdgap = s_reg.cmdgap - CNT_W'(1);
		end
		case (s_reg.st)
			PDX_C_RUN: begin
				s_next.cs = 1'b0;
				if (s_reg.cnt == '0 && cmd_req_i && !pd_req_i) begin
					s_next.cs = 1'b1;
					s_next.ca = cmd_ca_i;
					s_next.ack = 1'b1;
					s_next.cmdgap = C_CMDCKE;
					// Post-command clock hold for register write or calibration
					s_next.hold = cmd_is_mrw_i ? C_MRWCKEL :
						(cmd_is_zq_i ? C_ZQCKE : C_CKELCK);
				end else if (pd_req_i && s_reg.cnt == '0 && s_reg.cmdgap == '0
						&& !cmd_req_i && !blocking_op_i && !osc_run_i) begin
					s_next.st = PDX_C_PRE;
					s_next.cnt = C_CSCKE;
				end
			end
			PDX_C_PRE: begin
				// Chip select already settled low before the fall
				if (s_reg.cnt == '0) begin
					s_next.cke = 1'b0;
					s_next.st = PDX_C_LOW;
					s_next.cnt = pdx_max(s_reg.hold, C_CKELCS);
				end
			end
			PDX_C_LOW: begin
				s_next.cs = 1'b0;
				s_next.ck = 1'b1;
				if (s_reg.cnt == '0) begin
					s_next.st = PDX_C_DOWN;
					s_next.cnt = (C_CKE > C_CKELCK) ? C_CKE - C_CKELCK : CNT_W'(0);
				end
			end
			PDX_C_DOWN: begin
				s_next.stop_ok = 1'b1;
				s_next.ck = 1'b0;
				// Low pulse must still reach its minimum before waking
				if (s_reg.cnt == '0 && (!pd_req_i || refresh_due_i)) begin
					s_next.st = PDX_C_WAKE;
					s_next.ck = 1'b1;
					s_next.stop_ok = 1'b0;
					s_next.cnt = pdx_max(C_CKCKEH, C_CSCKE);
				end
			end
			PDX_C_WAKE: begin
				s_next.ck = 1'b1;
				if (s_reg.cnt == '0) begin
					s_next.cke = 1'b1;
					s_next.st = PDX_C_XP;
					s_next.cnt = pdx_max(C_XP, C_CKEHCS);
				end
			end
			PDX_C_XP: begin
				s_next.cs = 1'b0;
				if (s_reg.cnt == '0) begin
					s_next.st = PDX_C_RUN;
					s_next.hold = C_CKELCK;
					// High pulse minimum also covered before next fall
					s_next.cnt = (C_CKE > C_XP) ? C_CKE - C_XP : CNT_W'(0);
				end
			end
			default: begin
				s_next.st = PDX_C_RUN;
			end
		endcase
		if (sys_rst_i) begin
			s_next = '0;
			s_next.st = PDX_C_RUN;
			s_next.cke = 1'b1;
			s_next.ck = 1'b1;
			s_next.hold = C_CKELCK;
		end
		// Power-down flag kept as its own flop so the output needs no gate
		s_next.pd = ~s_next.cke;
	end

	always_ff @(posedge clock_i) begin
		s_reg <= s_next;
	end

	assign link.cke      = s_reg.cke;
	assign link.cs       = s_reg.cs;
	assign link.clk_valid = s_reg.ck;
	assign link.ca       = s_reg.ca;
	assign cmd_ack_o     = s_reg.ack;
	assign in_pd_o       = s_reg.pd;
	assign clk_stop_ok_o = s_reg.stop_ok;
endmodule
`default_nettype wire

/* File: hw/pdx_pkg.sv */
// Package with timing constants and types shared by both power-down ends
package pdx_pkg;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int T_CKE_PS = 7500;
	localparam int N_CKE = 4;
	localparam int T_CMDCKE_PS = 1750;
	localparam int N_CMDCKE = 3;
	localparam int T_CKELCK_PS = 5000;
	localparam int N_CKELCK = 5;
	localparam int T_CKELCS_PS = 5000;
	localparam int N_CKELCS = 5;
	localparam int T_CKCKEH_PS = 1750;
	localparam int N_CKCKEH = 3;
	localparam int T_XP_PS = 7500;
	localparam int N_XP = 5;
	localparam int T_CKEHCS_PS = 7500;
	localparam int N_CKEHCS = 5;
	localparam int T_MRWCKEL_PS = 14000;
	localparam int N_MRWCKEL = 10;
	localparam int T_ZQCKE_PS = 1750;
	localparam int N_ZQCKE = 3;
	localparam int T_CSCKE_PS = 1750;
	localparam int CNT_W = 5;
	localparam logic [2:0] ODT_CA_LSB = 3'h4;

	// Larger of cycle minimum and time minimum in whole cycles
	function automatic int pdx_cyc(input int ps, input int n);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return (c > n) ? c : n;
	endfunction

	localparam logic [CNT_W-1:0] C_CKE     = CNT_W'(pdx_cyc(T_CKE_PS, N_CKE));
	localparam logic [CNT_W-1:0] C_CMDCKE  = CNT_W'(pdx_cyc(T_CMDCKE_PS, N_CMDCKE));
	localparam logic [CNT_W-1:0] C_CKELCK  = CNT_W'(pdx_cyc(T_CKELCK_PS, N_CKELCK));
	localparam logic [CNT_W-1:0] C_CKELCS  = CNT_W'(pdx_cyc(T_CKELCS_PS, N_CKELCS));
	localparam logic [CNT_W-1:0] C_CKCKEH  = CNT_W'(pdx_cyc(T_CKCKEH_PS, N_CKCKEH));
	localparam logic [CNT_W-1:0] C_XP      = CNT_W'(pdx_cyc(T_XP_PS, N_XP));
	localparam logic [CNT_W-1:0] C_CKEHCS  = CNT_W'(pdx_cyc(T_CKEHCS_PS, N_CKEHCS));
	localparam logic [CNT_W-1:0] C_MRWCKEL = CNT_W'(pdx_cyc(T_MRWCKEL_PS, N_MRWCKEL));
	localparam logic [CNT_W-1:0] C_ZQCKE   = CNT_W'(pdx_cyc(T_ZQCKE_PS, N_ZQCKE));
	localparam logic [CNT_W-1:0] C_CSCKE   = CNT_W'(pdx_cyc(T_CSCKE_PS, 1));

	// Power-down class reported by the memory
	typedef enum logic [1:0] {
		PDX_PD_NONE   = 2'b00,
		PDX_PD_IDLE   = 2'b01,
		PDX_PD_ACTIVE = 2'b10,
		PDX_PD_SELF   = 2'b11
	} pdx_pd_t;

	// Controller sequencer states
	typedef enum logic [2:0] {
		PDX_C_RUN   = 3'b000,
		PDX_C_PRE   = 3'b001,
		PDX_C_LOW   = 3'b010,
		PDX_C_DOWN  = 3'b011,
		PDX_C_WAKE  = 3'b100,
		PDX_C_XP    = 3'b101
	} pdx_cst_t;
endpackage

/* File: hw/pdx_if.sv */
// Interface joining the controller and memory power-down ends
`timescale 1ns/1ns
`default_nettype none
interface pdx_if;
	logic       cke;
	logic       cs;
	logic       clk_valid;
	logic [5:0] ca;
	modport ctrl (output cke, output cs, output clk_valid, output ca);
	modport mem  (input cke, input cs, input clk_valid, input ca);
endinterface
`default_nettype wire

/* File: hw/pdx_mem.sv */
// Memory end: power-down entry, exit, receiver gating and classification
`timescale 1ns/1ns
`default_nettype none
module pdx_mem
	import pdx_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	pdx_if.mem              link,
	input  wire logic       bank_open_i,
	input  wire logic       self_refresh_i,
	input  wire logic       busy_op_i,
	input  wire logic [2:0] odt_field_i,
	input  wire logic       odt_enable_i,
	input  wire logic       vddq_ok_i,
	output var  logic       power_down_o,
	output var  logic       buffers_on_o,
	output var  logic       receivers_on_o,
	output var  logic       low_current_o,
	output var  logic       refresh_run_o,
	output var  logic       ca_term_o,
	output var  logic [1:0] pd_class_o,
	output var  logic       cmd_valid_o,
	output var  logic [5:0] cmd_ca_o
);
	typedef struct packed {
		logic             pd;
		logic             buf_on;
		logic             rx_on;
		logic             low_i;
		logic             refr;
		logic             term;
		pdx_pd_t          cls;
		logic [CNT_W-1:0] cnt;
		logic             cv;
		logic [5:0]       ca;
	} pdx_mst_t;

	pdx_mst_t st_reg;
	pdx_mst_t st_next;

	// Next state; entry and exit follow clock-enable directly
	always_comb begin
		st_next = st_reg;
		st_next.cv = 1'b0;
		st_next.pd = ~link.cke;
		st_next.buf_on = link.cke;
		if (link.cke) begin
			st_next.rx_on = 1'b1;
			st_next.cnt = '0;
			st_next.cls = PDX_PD_NONE;
			st_next.low_i = 1'b0;
		end else begin
			if (!st_reg.pd) begin
				// Class latched at entry
				st_next.cls = self_refresh_i ? PDX_PD_SELF :
					(bank_open_i ? PDX_PD_ACTIVE : PDX_PD_IDLE);
			end
			if (st_reg.cnt < C_CKELCK) begin
				st_next.cnt = st_reg.cnt + CNT_W'(1);
			end else begin
				st_next.rx_on = 1'b0;
			end
			// Pending row or refresh work keeps the higher current
			st_next.low_i = ~busy_op_i;
		end
		// Refresh runs only while self-refresh is requested, in or out of power-down
		st_next.refr = self_refresh_i;
		// Command bus termination independent of power state
		st_next.term = odt_enable_i && (odt_field_i != 3'h0) && vddq_ok_i;
		// Commands accepted only with receivers on and chip select high
		if (link.cke && st_reg.rx_on && link.cs && link.clk_valid) begin
			st_next.cv = 1'b1;
			st_next.ca = link.ca;
		end
		if (sys_rst_i) begin
			st_next = '0;
			st_next.buf_on = 1'b1;
			st_next.rx_on = 1'b1;
			st_next.cls = PDX_PD_NONE;
		end
	end

	always_ff @(posedge clock_i) begin
		st_reg <= st_next;
	end

	// Outputs straight from state
	assign power_down_o   = st_reg.pd;
	assign buffers_on_o   = st_reg.buf_on;
	assign receivers_on_o = st_reg.rx_on;
	assign low_current_o  = st_reg.low_i;
	assign refresh_run_o  = st_reg.refr;
	assign ca_term_o      = st_reg.term;
	assign pd_class_o     = st_reg.cls;
	assign cmd_valid_o    = st_reg.cv;
	assign cmd_ca_o       = st_reg.ca;
endmodule
`default_nettype wire

/* File: test/pdx_properties.sv */
// Link timing checker for the power-down controller and memory pair
`timescale 1ns/1ns
`default_nettype none
module pdx_properties (
	input wire logic       clock_i,
	input wire logic       sys_rst_i,
	input wire logic       cke,
	input wire logic       cs,
	input wire logic       clk_valid,
	input wire logic [5:0] ca
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// Pulse widths and select hold around each clock-enable edge
	cke_low_width_a: assert property (
		$fell(cke) |-> !cke [*4]) else $error("cke low pulse short");
	cke_high_width_a: assert property (
		$rose(cke) |-> cke [*4]) else $error("cke high pulse short");
	cs_low_hold_a: assert property (
		$fell(cke) |-> !cs [*5]) else $error("cs not held low after entry");
	clk_hold_a: assert property (
		$fell(cke) |-> clk_valid [*5]) else $error("clock dropped too early");
	// A command too close to the fall would be cut off inside the memory
	cmd_gap_a: assert property (
		$fell(cke) |-> !$past(cs, 1) && !$past(cs, 2) && !$past(cs, 3))
		else $error("command too close to entry");
	exit_gap_a: assert property (
		$rose(cke) |-> !cs [*5]) else $error("command inside exit latency");
	wake_clock_a: assert property (
		$rose(cke) |-> $past(clk_valid, 1) && $past(clk_valid, 2) && $past(clk_valid, 3))
		else $error("clock not valid before exit");
	xp_clock_a: assert property (
		$rose(cke) |-> clk_valid [*5]) else $error("clock stopped during exit");
	stop_window_a: assert property (
		!clk_valid |-> !cke && !$past(cke, 5)) else $error("clock stopped outside window");
	cmd_awake_a: assert property (
		cs |-> cke) else $error("command while asleep");

	cover property ($fell(cke));
	cover property ($rose(cke));
	cover property (!clk_valid);
	cover property (cs && ca != 6'h00);
endmodule
`default_nettype wire

/* File: test/dram_power_down_entry_exit_tb_top.sv */
// Testbench joining both power-down ends over one link
`timescale 1ns/1ns
`default_nettype none
module dram_power_down_entry_exit_tb_top;
	import pdx_pkg::*;
	logic       clock_i, sys_rst_i, pd_req_i, cmd_req_i, cmd_is_mrw_i, cmd_is_zq_i;
	logic       blocking_op_i, osc_run_i, refresh_due_i, bank_open_i, self_refresh_i;
	logic       busy_op_i, odt_enable_i, vddq_ok_i, cmd_ack_o, in_pd_o, clk_stop_ok_o;
	logic       power_down_o, buffers_on_o, receivers_on_o, low_current_o, refresh_run_o;
	logic       ca_term_o, cmd_valid_o;
	logic [5:0] cmd_ca_i, cmd_ca_o;
	logic [2:0] odt_field_i;
	logic [1:0] pd_class_o, cls_e;
	logic [5:0] ca_q[$];
	logic [1:0] cls_q[$];
	int         err_count, checks, cyc;

	pdx_if pdx_if_i ();
	pdx_ctrl pdx_ctrl_i (.clock_i, .sys_rst_i, .link(pdx_if_i), .pd_req_i, .cmd_req_i,
		.cmd_ca_i, .cmd_is_mrw_i, .cmd_is_zq_i, .blocking_op_i, .osc_run_i, .refresh_due_i,
		.cmd_ack_o, .in_pd_o, .clk_stop_ok_o);
	pdx_mem pdx_mem_i (.clock_i, .sys_rst_i, .link(pdx_if_i), .bank_open_i, .self_refresh_i,
		.busy_op_i, .odt_field_i, .odt_enable_i, .vddq_ok_i, .power_down_o, .buffers_on_o,
		.receivers_on_o, .low_current_o, .refresh_run_o, .ca_term_o, .pd_class_o,
		.cmd_valid_o, .cmd_ca_o);
	pdx_properties pdx_properties_i (.clock_i, .sys_rst_i, .cke(pdx_if_i.cke),
		.cs(pdx_if_i.cs), .clk_valid(pdx_if_i.clk_valid), .ca(pdx_if_i.ca));

	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	task automatic finish_test();
		$display("TB: checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic note(input string nm, input logic [5:0] e, input logic [5:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_cmd(input logic [5:0] e, input logic [5:0] g);
		note("cmd_ca", e, g);
	endtask
	task automatic cmp_cls(input logic [1:0] e, input logic [1:0] g);
		note("pd_class", 6'(e), 6'(g));
	endtask
	task automatic cmp_lvl(input string nm, input logic e, input logic g);
		note(nm, 6'(e), 6'(g));
	endtask
	// Inputs always move a fixed 2 ns after the edge, clear of sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask
	task automatic wait_pd(input logic v);
		for (int i = 0; i < 60 && in_pd_o !== v; i++) tick(1);
		cmp_lvl("in_pd", v, in_pd_o);
	endtask
	// Request held until the acknowledge edge, then released for one edge
	task automatic send(input logic mode_register_write, input logic zq);
		cmd_ca_i = 6'($urandom);
		cmd_is_mrw_i = mode_register_write;
		cmd_is_zq_i = zq;
		cmd_req_i = 1'b1;
		ca_q.push_back(cmd_ca_i);
		for (int i = 0; i < 30; i++) begin
			tick(1);
			if (cmd_ack_o === 1'b1) break;
		end
		cmd_req_i = 1'b0;
		tick(1);
	endtask
	task automatic enter(input logic [1:0] cls, input int hold);
		int n;
		cls_q.push_back(cls);
		pd_req_i = 1'b1;
		for (n = 0; n < 60 && pdx_if_i.cke !== 1'b0; n++) tick(1);
		for (n = 0; n < 40 && pdx_if_i.clk_valid === 1'b1; n++) tick(1);
		cmp_lvl("clk_hold", 1'b1, n >= hold);
		tick(2);
		cmp_lvl("stop_ok", 1'b1, clk_stop_ok_o);
		cmp_lvl("low_current", ~busy_op_i, low_current_o);
		cmp_lvl("ca_term", odt_enable_i & (|odt_field_i) & vddq_ok_i, ca_term_o);
	endtask
	task automatic leave();
		pd_req_i = 1'b0;
		wait_pd(1'b0);
		tick(6);
		cmp_lvl("receivers_on", 1'b1, receivers_on_o);
	endtask

	// Results matched in arrival order; the cycle counter cuts a hang short
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			finish_test();
		end
		if (!sys_rst_i && cmd_valid_o === 1'b1) begin
			cmp_cmd(ca_q.size() > 0 ? ca_q.pop_front() : 6'hXX, cmd_ca_o);
		end
		if (!sys_rst_i && $fell(receivers_on_o)) begin
			cls_e = cls_q.size() > 0 ? cls_q.pop_front() : 2'hX;
			cmp_cls(cls_e, pd_class_o);
			cmp_lvl("refresh_run", cls_e == 2'h3, refresh_run_o);
			cmp_lvl("buffers_off", 1'b0, buffers_on_o);
			cmp_lvl("power_down", 1'b1, power_down_o);
		end
	end

	initial begin
		{pd_req_i, cmd_req_i, cmd_is_mrw_i, cmd_is_zq_i, blocking_op_i, osc_run_i} = '0;
		{refresh_due_i, bank_open_i, self_refresh_i, busy_op_i, odt_enable_i} = '0;
		cmd_ca_i = 6'h00;
		odt_field_i = 3'h0;
		vddq_ok_i = 1'b1;
		err_count = 0;
		checks = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		void'($urandom(40));
		tick(10);
		sys_rst_i = 1'b0;
		cmp_lvl("rst_recv", 1'b1, receivers_on_o);
		repeat (4) send(1'b0, 1'b0);
		// Idle, active and self-refresh classes in turn
		for (int k = 0; k < 3; k++) begin
			bank_open_i = (k == 1);
			self_refresh_i = (k == 2);
			busy_op_i = 1'($urandom);
			{vddq_ok_i, odt_enable_i, odt_field_i} = 5'($urandom);
			send(1'b0, 1'b0);
			enter(2'(k + 1), 5);
			leave();
		end
		{bank_open_i, self_refresh_i} = 2'h0;
		send(1'b1, 1'b0);
		enter(2'h1, 10);
		leave();
		send(1'b0, 1'b1);
		enter(2'h1, 3);
		leave();
		// Entry must wait out an oscillator run, then a blocking operation and a forced refresh exit
		for (int k = 0; k < 2; k++) begin
			{blocking_op_i, osc_run_i} = 2'(k + 1);
			pd_req_i = 1'b1;
			tick(20);
			cmp_lvl("held_off", 1'b0, in_pd_o);
			{blocking_op_i, osc_run_i} = 2'h0;
			enter(2'h1, 5);
			refresh_due_i = (k == 1);
			tick(8);
			wait_pd(k == 0);
			leave();
			refresh_due_i = 1'b0;
		end
		repeat (2) send(1'b0, 1'b0);
		tick(5);
		cmp_lvl("queues_empty", 1'b1, ca_q.size() == 0 && cls_q.size() == 0);
		finish_test();
	end
endmodule
`default_nettype wire
